// ### common/fan_config_regs.vh
// Register indices, field positions, reset values and constants of the fan
// configuration and voltage readback bank. Assumes the includer maps an
// index to byte address index*4 on the register bus.
`ifndef FAN_CONFIG_REGS_VH
`define FAN_CONFIG_REGS_VH

// ****************************************************************
// Register indices
// ****************************************************************
`define IDX_SMOOTH_SYNC 8'h10
`define IDX_HYST_DIS 8'h11
`define IDX_VOLT_BASE 8'h20
`define IDX_VOLT_CORE 8'h21
`define IDX_VOLT_SUPPLY 8'h22
`define IDX_VOLT_5V 8'h23
`define IDX_VOLT_LAST 8'h24
`define IDX_LOCK_CFG 8'h40
`define IDX_INT_STATUS 8'h41
`define IDX_INT_MASK 8'h42
`define IDX_EXT_RES1 8'h76
`define IDX_EXT_RES2 8'h77

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_REMOTE1_RAMP_X4 0
`define BIT_LOCAL_RAMP_X4 1
`define BIT_REMOTE2_RAMP_X4 2
`define BIT_OVERTEMP_IN_MANUAL 3
`define BIT_SYNC_FOLLOWER 4
`define BIT_SYNC_LEADER 5
`define BIT_CORE_UNDERVOLT_SLEEP 6
`define BIT_EXTRA_LONG_RAMP 7
`define BIT_HYST_DISABLE 0
`define BIT_LOCK 1
`define BIT_INT_OVERTEMP 0
`define BIT_INT_CORE_LOW 1

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_SMOOTH_SYNC 8'h00
`define RST_HYST_DIS 1'b0
`define RST_READING 8'h00
`define RST_RDATA 8'h00
`define RST_LSB 2'h0
`define RST_INT 2'h0
`define PENDING_ALL 5'h1f
`define PENDING_NONE 5'h00

// ****************************************************************
// Smoothing scale: extra 39.2 percent is t*401/1024
// ****************************************************************
`define EXTRA_NUM 10'h191
`define EXTRA_SHIFT 10
`define SPINUP_CYCLES_DEF 200000

// ****************************************************************
// Undervolt sequencer states
// ****************************************************************
`define UV_NORMAL 2'h0
`define UV_SLEEP 2'h1
`define UV_SPINUP 2'h2

`endif

// ### src/fan_config_voltage_readback.v
// Fan smoothing/sync configuration, overtemperature control, core undervolt
// sleep sequencing and frozen voltage readback, as an APB slave.
// Assumes conversion results, temperature comparisons and limits arrive
// synchronous to pclk from the measurement engine.
//
// Behaviour
// R1 - Bit 0 quadruples fan 1 smoothing
// R2 - Bit 1 quadruples fan 2 smoothing
// R3 - Bit 2 quadruples fan 3 smoothing
// R4 - Bit 3 keeps overtemperature active in manual
// R5 - Bit 4 selects sync follower
// R6 - Bit 5 selects sync leader
// R7 - Core low: status flag, alert, suspend monitor
// R8 - Core recovered: resume, spin up, restore
// R9 - Bit 7 adds 39.2 percent smoothing
// R10 - Overtemperature overrides every fan setting; fan_sleep is not masked by fan_force_full
// R11 - Hysteresis disable bit removes overtemperature hysteresis
// R12 - Software leaves reserved bits unwritten
// R13 - Lock makes hysteresis register read-only
// R14 - Five read-only voltage MSB readings
// R15 - Software reads extended registers first
// R16 - Extended read freezes readings until read
// R17 - Lock bit set once until power cycle
// R18 - Readings ignore writes, update from conversions
`timescale 1ns/1ps
`include "fan_config_regs.vh"

module fan_config_voltage_readback #(
  parameter ADDR_W = 10,
  parameter BASE_W = 16,
  parameter SPINUP_CYCLES = `SPINUP_CYCLES_DEF
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Interrupt
  output wire irq,
  // Conversion results, 10 bits each, and the 8-bit core low limit
  input wire conv_valid,
  input wire [9:0] conv_2v5,
  input wire [9:0] conv_core,
  input wire [9:0] conv_supply,
  input wire [9:0] conv_5v,
  input wire [9:0] conv_12v,
  input wire [7:0] core_low_limit,
  // Fan smoothing
  input wire [BASE_W-1:0] fan1_smooth_base,
  input wire [BASE_W-1:0] fan2_smooth_base,
  input wire [BASE_W-1:0] fan3_smooth_base,
  output reg [BASE_W+2:0] fan1_smooth_time,
  output reg [BASE_W+2:0] fan2_smooth_time,
  output reg [BASE_W+2:0] fan3_smooth_time,
  // Fan synchronisation
  output wire sync_leader_enable,
  output wire sync_follower_enable,
  // Overtemperature
  input wire temp_above_limit,
  input wire temp_above_release,
  input wire manual_mode,
  input wire overtemp_signal_i,
  output wire overtemp_signal_o,
  output wire overtemp_signal_oe,
  output wire fan_force_full,
  // Core undervolt sequencing
  output wire processor_hot_monitor,
  output wire fan_sleep,
  output wire fan_spinup
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire [7:0] idx;
  wire access;
  wire wr;
  wire rd;
  wire setup;
  reg mapped;
  reg [7:0] rdata;

  assign idx = paddr[9:2];
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  // Setup cycle: read data is captured here, one edge ahead of the access
  assign setup = psel & ~penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  reg [7:0] smooth_sync;
  reg hyst_disable;
  reg lock;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smooth_sync <= `RST_SMOOTH_SYNC;
    end else if (wr && idx == `IDX_SMOOTH_SYNC) begin
      smooth_sync <= pwdata[7:0];
    end
  end

  // Only bit 0 is stored; reserved bits are dropped and read back as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyst_disable <= `RST_HYST_DIS;
    end else if (wr && idx == `IDX_HYST_DIS && !lock) begin // R13
      hyst_disable <= pwdata[`BIT_HYST_DISABLE]; // R11
    end
  end

  // Write-once: nothing but reset clears it, so a rogue write cannot unlock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= 1'b0;
    end else if (wr && idx == `IDX_LOCK_CFG && pwdata[`BIT_LOCK]) begin
      lock <= 1'b1; // R17
    end
  end

  assign sync_follower_enable = smooth_sync[`BIT_SYNC_FOLLOWER]; // R5
  assign sync_leader_enable = smooth_sync[`BIT_SYNC_LEADER]; // R6

  // ****************************************************************
  // Fan smoothing times
  // ****************************************************************
  function [BASE_W+2:0] scale_time;
    input [BASE_W-1:0] base;
    input quad;
    input extra;
    reg [BASE_W+1:0] t4;
    reg [BASE_W+11:0] prod;
    begin
      // The extra ramp scales the quadrupled time, so both options stack
      t4 = quad ? {base, 2'h0} : {2'h0, base};
      prod = t4 * `EXTRA_NUM;
      scale_time = extra ? ({1'b0, t4} + prod[BASE_W+11:`EXTRA_SHIFT]) : {1'b0, t4};
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan1_smooth_time <= {(BASE_W+3){1'b0}};
      fan2_smooth_time <= {(BASE_W+3){1'b0}};
      fan3_smooth_time <= {(BASE_W+3){1'b0}};
    end else begin
      fan1_smooth_time <= scale_time(fan1_smooth_base, smooth_sync[`BIT_REMOTE1_RAMP_X4],
                                     smooth_sync[`BIT_EXTRA_LONG_RAMP]); // R1 R9
      fan2_smooth_time <= scale_time(fan2_smooth_base, smooth_sync[`BIT_LOCAL_RAMP_X4],
                                     smooth_sync[`BIT_EXTRA_LONG_RAMP]); // R2 R9
      fan3_smooth_time <= scale_time(fan3_smooth_base, smooth_sync[`BIT_REMOTE2_RAMP_X4],
                                     smooth_sync[`BIT_EXTRA_LONG_RAMP]); // R3 R9
    end
  end

  // ****************************************************************
  // Overtemperature
  // ****************************************************************
  reg overtemp_active;
  wire overtemp_allowed;

  // With hysteresis the event holds until the lower release threshold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overtemp_active <= 1'b0;
    end else if (temp_above_limit) begin
      overtemp_active <= 1'b1;
    end else if (hyst_disable) begin
      overtemp_active <= 1'b0; // R11
    end else if (!temp_above_release) begin
      overtemp_active <= 1'b0;
    end
  end

  assign overtemp_allowed = !manual_mode || smooth_sync[`BIT_OVERTEMP_IN_MANUAL]; // R4
  // Open drain, active low: only ever pull low
  assign overtemp_signal_o = 1'b0;
  assign overtemp_signal_oe = overtemp_active & overtemp_allowed;
  // Raised even during sleep; fan_sleep is not masked and stays high alongside it
  assign fan_force_full = overtemp_active & overtemp_allowed; // R10

  // ****************************************************************
  // Voltage readings and freeze
  // ****************************************************************
  reg [7:0] msb [0:4];
  reg [1:0] lsb [0:4];
  reg [4:0] pending;
  reg [7:0] core_latest;
  wire [49:0] conv_all;
  wire ext_read;
  integer i;

  assign conv_all = {conv_12v, conv_5v, conv_supply, conv_core, conv_2v5};
  // Freeze in the setup cycle, when the read data is captured, so the frozen
  // copy is exactly what the extended read returned
  assign ext_read = setup && !pwrite && (idx == `IDX_EXT_RES1 || idx == `IDX_EXT_RES2);

  // An access touches one register, so a freeze and its release never collide
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= `PENDING_NONE;
    end else if (ext_read) begin
      pending <= `PENDING_ALL; // R16
    end else if (rd && idx >= `IDX_VOLT_BASE && idx <= `IDX_VOLT_LAST) begin
      pending[idx[2:0]] <= 1'b0;
    end
  end

  // Bus writes never reach these; only conversions do
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 5; i = i + 1) begin
        msb[i] <= `RST_READING;
        lsb[i] <= `RST_LSB;
      end
    end else if (conv_valid) begin
      for (i = 0; i < 5; i = i + 1) begin
        if (!pending[i] && !ext_read) begin
          msb[i] <= conv_all[i*10+2 +: 8]; // R18
        end
        if (pending == `PENDING_NONE && !ext_read) begin
          lsb[i] <= conv_all[i*10 +: 2]; // R16
        end
      end
    end
  end

  // Undervolt detection must not stall behind a frozen reading
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_latest <= `RST_READING;
    end else if (conv_valid) begin
      core_latest <= conv_core[9:2];
    end
  end

  // ****************************************************************
  // Core undervolt sequencer
  // ****************************************************************
  reg [1:0] uv_state;
  reg [1:0] next_uv_state;
  reg [31:0] spin_cnt;
  wire core_low;

  assign core_low = smooth_sync[`BIT_CORE_UNDERVOLT_SLEEP] && (core_latest < core_low_limit);

  always @* begin
    next_uv_state = uv_state;
    case (uv_state)
      `UV_NORMAL: begin
        if (core_low) begin
          next_uv_state = `UV_SLEEP; // R7
        end
      end
      `UV_SLEEP: begin
        if (!core_low) begin
          next_uv_state = `UV_SPINUP; // R8
        end
      end
      `UV_SPINUP: begin
        // A fresh dip during spin-up sends the fans back to sleep
        if (core_low) begin
          next_uv_state = `UV_SLEEP;
        end else if (spin_cnt == SPINUP_CYCLES - 1) begin
          next_uv_state = `UV_NORMAL; // R8
        end
      end
      default: begin
        next_uv_state = `UV_NORMAL;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_state <= `UV_NORMAL;
      spin_cnt <= 32'h0;
    end else begin
      uv_state <= next_uv_state;
      if (uv_state == `UV_SPINUP) begin
        spin_cnt <= spin_cnt + 32'h1;
      end else begin
        spin_cnt <= 32'h0;
      end
    end
  end

  assign processor_hot_monitor = (uv_state != `UV_SLEEP); // R7 R8
  assign fan_sleep = (uv_state == `UV_SLEEP);
  assign fan_spinup = (uv_state == `UV_SPINUP); // R8

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  reg [1:0] int_status;
  reg [1:0] int_mask;
  wire [1:0] int_set;
  wire [1:0] int_clr;

  // Bit 0 also catches an outside device pulling the overtemperature pin
  assign int_set = {core_low, overtemp_signal_oe | ~overtemp_signal_i}; // R7
  assign int_clr = (wr && idx == `IDX_INT_STATUS) ? pwdata[1:0] : 2'h0;

  // A set in the clearing cycle survives the write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= `RST_INT;
      int_mask <= `RST_INT;
    end else begin
      int_status <= (int_status & ~int_clr) | int_set;
      if (wr && idx == `IDX_INT_MASK) begin
        int_mask <= pwdata[1:0];
      end
    end
  end

  assign irq = |(int_status & int_mask); // R7

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Unmapped indices read as zero and raise pslverr
  always @* begin
    rdata = 8'h00;
    mapped = 1'b1;
    case (idx)
      `IDX_SMOOTH_SYNC: rdata = smooth_sync;
      `IDX_HYST_DIS: rdata = {7'h00, hyst_disable};
      `IDX_LOCK_CFG: rdata = {6'h00, lock, 1'b0};
      `IDX_INT_STATUS: rdata = {6'h00, int_status};
      `IDX_INT_MASK: rdata = {6'h00, int_mask};
      `IDX_EXT_RES1: rdata = {lsb[0], lsb[1], lsb[2], lsb[3]};
      `IDX_EXT_RES2: rdata = {lsb[4], 6'h00};
      `IDX_VOLT_BASE: rdata = msb[0]; // R14
      `IDX_VOLT_CORE: rdata = msb[1];
      `IDX_VOLT_SUPPLY: rdata = msb[2];
      `IDX_VOLT_5V: rdata = msb[3];
      `IDX_VOLT_LAST: rdata = msb[4];
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Read data register
  // ****************************************************************
  reg [7:0] rdata_q;

  // Captured in the setup cycle: prdata comes from a flip-flop yet still
  // stands through the whole zero-wait access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `RST_RDATA;
    end else if (setup && !pwrite) begin
      rdata_q <= rdata;
    end
  end

  assign prdata = {24'h000000, rdata_q};

endmodule // fan_config_voltage_readback

// ### tb/fan_config_voltage_readback_chk.sv
// Port checker for the fan configuration and voltage readback bank.
// Assumes APB index = paddr[9:2] and the 401/1024 scale for extra ramp.
`timescale 1ns/1ps
module fan_config_voltage_readback_chk #(
  parameter ADDR_W = 10,
  parameter BASE_W = 16
) (
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  // Fans
  input wire [BASE_W-1:0] fan1_smooth_base,
  input wire [BASE_W-1:0] fan2_smooth_base,
  input wire [BASE_W-1:0] fan3_smooth_base,
  input wire [BASE_W+2:0] fan1_smooth_time,
  input wire [BASE_W+2:0] fan2_smooth_time,
  input wire [BASE_W+2:0] fan3_smooth_time,
  input wire sync_leader_enable,
  input wire sync_follower_enable,
  // Overtemperature and undervolt
  input wire temp_above_limit,
  input wire manual_mode,
  input wire overtemp_signal_oe,
  input wire fan_force_full,
  input wire processor_hot_monitor,
  input wire fan_sleep,
  input wire fan_spinup
);
  // ****************************************************************
  // Shadow of the unlocked fan register
  // ****************************************************************
  reg [7:0] cfg6;
  wire acc = psel && penable;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg6 <= 8'h00;
    else if (acc && pwrite && paddr[9:2] == 8'h10) cfg6 <= pwdata[7:0];
  end
  function [BASE_W+2:0] sc(input [BASE_W-1:0] b, input q, input e);
    reg [BASE_W+2:0] t;
    reg [BASE_W+12:0] m;
    begin
      t = q ? {1'b0, b, 2'b00} : {3'b000, b};
      m = t * 10'd401;
      sc = t + (e ? m[BASE_W+12:10] : {(BASE_W+3){1'b0}});
    end
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_ramp1;
    1 |=> fan1_smooth_time == sc($past(fan1_smooth_base), $past(cfg6[0]), $past(cfg6[7]));
  endproperty
  a_ramp1: assert property (p_ramp1) else $error("fan 1 time wrong");
  property p_ramp2;
    1 |=> fan2_smooth_time == sc($past(fan2_smooth_base), $past(cfg6[1]), $past(cfg6[7]));
  endproperty
  a_ramp2: assert property (p_ramp2) else $error("fan 2 time wrong");
  property p_ramp3;
    1 |=> fan3_smooth_time == sc($past(fan3_smooth_base), $past(cfg6[2]), $past(cfg6[7]));
  endproperty
  a_ramp3: assert property (p_ramp3) else $error("fan 3 time wrong");
  property p_sync;
    sync_leader_enable == cfg6[5] && sync_follower_enable == cfg6[4];
  endproperty
  a_sync: assert property (p_sync) else $error("sync select wrong");
  property p_manual;
    manual_mode && !cfg6[3] |-> !overtemp_signal_oe;
  endproperty
  a_manual: assert property (p_manual) else $error("overtemp in manual");
  property p_force;
    temp_above_limit && !manual_mode ##1 !manual_mode |-> overtemp_signal_oe && fan_force_full;
  endproperty
  a_force: assert property (p_force) else $error("overtemp not forced");
  property p_sleep;
    fan_sleep |-> !processor_hot_monitor && !fan_spinup;
  endproperty
  a_sleep: assert property (p_sleep) else $error("monitor on in sleep");
  property p_spin;
    $fell(fan_sleep) |-> (fan_spinup && processor_hot_monitor) [*8] ##1 !fan_spinup;
  endproperty
  a_spin: assert property (p_spin) else $error("spin-up wrong");
  property p_volt;
    acc && !pwrite && paddr[9:2] >= 8'h20 && paddr[9:2] <= 8'h24 |-> !pslverr && prdata[31:8] == 0;
  endproperty
  a_volt: assert property (p_volt) else $error("reading access wrong");
  c_sleep: cover property ($fell(fan_sleep));
  c_force: cover property ($rose(overtemp_signal_oe));
  c_err: cover property (acc && pslverr);
endmodule // fan_config_voltage_readback_chk

bind fan_config_voltage_readback fan_config_voltage_readback_chk #(
  .ADDR_W(ADDR_W), .BASE_W(BASE_W)) chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .fan1_smooth_base(fan1_smooth_base), .fan2_smooth_base(fan2_smooth_base),
  .fan3_smooth_base(fan3_smooth_base), .fan1_smooth_time(fan1_smooth_time),
  .fan2_smooth_time(fan2_smooth_time), .fan3_smooth_time(fan3_smooth_time),
  .sync_leader_enable(sync_leader_enable), .sync_follower_enable(sync_follower_enable),
  .temp_above_limit(temp_above_limit), .manual_mode(manual_mode),
  .overtemp_signal_oe(overtemp_signal_oe), .fan_force_full(fan_force_full),
  .processor_hot_monitor(processor_hot_monitor), .fan_sleep(fan_sleep),
  .fan_spinup(fan_spinup));

// ### tb/fan_config_voltage_readback_tb_top.sv
// Self-checking bench for the fan configuration and readback bank.
// Assumes a zero-wait APB slave at byte address 4*index.
`timescale 1ns/1ps
module fan_config_voltage_readback_tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cv = 0;
  reg hi = 0, rel = 0, man = 0, ext_n = 1, se;
  reg [7:0] lim = 8'h80;
  reg [9:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [49:0] cvec = 0;
  reg [15:0] b1 = 16'h1234;
  wire [31:0] prdata;
  wire pready, pslverr, irq, sl, sf, oe, ffull, phm, fsl, fsp, ot_o;
  wire [18:0] t1, t2, t3;
  // Open-drain pin: low while the block pulls it or the outside does
  wire ot_i = oe ? ot_o : ext_n;
  integer num_errors = 0, compares = 0;
  fan_config_voltage_readback #(.ADDR_W(10), .BASE_W(16), .SPINUP_CYCLES(8))
  fan_config_voltage_readback_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .conv_valid(cv), .conv_2v5(cvec[49:40]),
    .conv_core(cvec[39:30]), .conv_supply(cvec[29:20]), .conv_5v(cvec[19:10]),
    .conv_12v(cvec[9:0]), .core_low_limit(lim), .fan1_smooth_base(b1),
    .fan2_smooth_base(16'h0abc), .fan3_smooth_base(16'hffff), .fan1_smooth_time(t1),
    .fan2_smooth_time(t2), .fan3_smooth_time(t3), .sync_leader_enable(sl),
    .sync_follower_enable(sf), .temp_above_limit(hi), .temp_above_release(rel),
    .manual_mode(man), .overtemp_signal_i(ot_i), .overtemp_signal_o(ot_o), .overtemp_signal_oe(oe),
    .fan_force_full(ffull), .processor_hot_monitor(phm), .fan_sleep(fsl), .fan_spinup(fsp));
  initial forever #50 pclk = ~pclk;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input w, input [7:0] i, input [31:0] d);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      // Wait states end only on pready; the watchdog bounds a hang
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task rdc(input string nm, input [7:0] i, input [31:0] e);
    begin
      apb(0, i, 0);
      chk(nm, rd, e);
    end
  endtask
  task conv(input [49:0] v);
    begin
      cvec <= v;
      cv <= 1;
      @(posedge pclk);
      cv <= 0;
      @(posedge pclk);
    end
  endtask
  function [18:0] sc(input [15:0] b, input q, input e);
    reg [18:0] t;
    reg [28:0] m;
    begin
      t = q ? {1'b0, b, 2'b00} : {3'b000, b};
      m = t * 10'd401;
      sc = t + (e ? m[28:10] : 19'h0);
    end
  endfunction
  task rdv(input [49:0] v);
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) rdc("volt", 8'h20 + i[7:0], v[49-10*i -: 8]);
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_cfg;
    integer i;
    begin
      rdc("cfg7", 8'h11, 0);
      rdv(0);
      for (i = 0; i < 8; i = i + 1) begin
        apb(1, 8'h10, 32'h1 << i);
        rdc("cfg6", 8'h10, 32'h1 << i);
        chk("leader", sl, i == 5);
        chk("follower", sf, i == 4);
      end
      apb(1, 8'h10, 32'h85);
      @(posedge pclk);
      chk("fan1", t1, sc(b1, 1, 1));
      chk("fan2", t2, sc(16'h0abc, 0, 1));
      chk("fan3", t3, sc(16'hffff, 1, 1));
      b1 <= 16'h0001;
      apb(1, 8'h10, 32'h02);
      @(posedge pclk);
      chk("fan1", t1, 1);
      chk("fan2", t2, sc(16'h0abc, 1, 0));
      $display("test config done");
    end
  endtask
  task t_ot;
    begin
      apb(1, 8'h42, 1);
      hi <= 1;
      rel <= 1;
      apb(0, 8'h41, 0);
      chk("oe", oe, 1);
      chk("pin level", ot_o, 0);
      chk("irq", irq, 1);
      hi <= 0;
      apb(0, 8'h41, 0);
      chk("oe hyst", oe, 1);
      apb(1, 8'h11, 1);
      @(posedge pclk);
      chk("oe nohyst", oe, 0);
      rel <= 0;
      ext_n <= 0;
      apb(1, 8'h42, 0);
      ext_n <= 1;
      chk("irq masked", irq, 0);
      apb(1, 8'h42, 1);
      chk("irq", irq, 1);
      apb(1, 8'h41, 1);
      chk("irq clr", irq, 0);
      man <= 1;
      hi <= 1;
      apb(0, 8'h41, 0);
      chk("oe manual", oe, 0);
      apb(1, 8'h10, 8'h08);
      chk("force", ffull, 1);
      hi <= 0;
      man <= 0;
      apb(1, 8'h41, 3);
      $display("test overtemp done");
    end
  endtask
  task t_lock;
    begin
      apb(1, 8'h11, 0);
      apb(1, 8'h40, 2);
      rdc("lock", 8'h40, 2);
      apb(1, 8'h11, 1);
      rdc("cfg7", 8'h11, 0);
      apb(1, 8'h40, 0);
      rdc("lock", 8'h40, 2);
      rdc("unmapped", 8'h30, 0);
      chk("slverr", se, 1);
      $display("test lock done");
    end
  endtask
  task t_volt;
    reg [49:0] a, b;
    begin
      a = {10'h3ff, 10'h155, 10'h2aa, 10'h0f1, 10'h1c3};
      b = {10'h0c2, 10'h21d, 10'h0aa, 10'h3e5, 10'h13e};
      conv(a);
      apb(1, 8'h20, 8'h5a);
      rdv(a);
      rdc("ext1", 8'h76, {a[41:40], a[31:30], a[21:20], a[11:10]});
      rdc("ext2", 8'h77, {a[1:0], 6'h00});
      conv(b);
      rdc("ext1", 8'h76, {a[41:40], a[31:30], a[21:20], a[11:10]});
      rdv(a);
      conv(b);
      rdc("ext2", 8'h77, {b[1:0], 6'h00});
      rdv(b);
      $display("test readings done");
    end
  endtask
  task t_uv;
    begin
      apb(1, 8'h42, 2);
      apb(1, 8'h10, 8'h40);
      conv({10'h0, 10'h100, 30'h0});
      @(posedge pclk);
      chk("sleep", fsl, 1);
      chk("monitor", phm, 0);
      chk("irq", irq, 1);
      rdc("status", 8'h41, 2);
      conv({10'h0, 10'h3fc, 30'h0});
      @(posedge pclk);
      chk("spinup", fsp, 1);
      chk("monitor", phm, 1);
      repeat (10) @(posedge pclk);
      chk("spun", fsp, 0);
      lim <= 8'hff;
      repeat (2) @(posedge pclk);
      chk("limit strict", fsl, 0);
      apb(1, 8'h41, 2);
      chk("irq clr", irq, 0);
      $display("test undervolt done");
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    num_errors = num_errors + 1;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_cfg;
    t_ot;
    t_lock;
    t_volt;
    t_uv;
    give_verdict;
  end
endmodule // fan_config_voltage_readback_tb_top
